// *** ddd_pkg.sv ***
// Package of field layouts, codes and register offsets for the descriptor decoder
package ddd_pkg;

  // ==========================================================================
  // Descriptor geometry
  localparam int DWORDS = 8;
  localparam logic [2:0] LAST_DWORD = 3'h7;

  // ==========================================================================
  // Dword 0 fields
  localparam int KIND_HI = 31;
  localparam int KIND_LO = 29;
  localparam int IWF_BIT = 27;
  localparam int TTYPE_HI = 22;
  localparam int TTYPE_LO = 19;
  localparam int PRIO_HI = 18;
  localparam int PRIO_LO = 17;
  localparam int CRF_BIT = 16;
  localparam int TID_HI = 15;
  localparam int TID_LO = 0;
  localparam logic [2:0] KIND_DATA = 3'h1;

  // ==========================================================================
  // Dword 1, 2, 6, 7 fields
  localparam int LEN_HI = 25;
  localparam int LEN_LO = 0;
  localparam int TT_HI = 27;
  localparam int TT_LO = 26;
  localparam int FA_LOW_HI = 31;
  localparam int FA_LOW_LO = 30;
  localparam int CFG_OFS_HI = 23;
  localparam int CFG_OFS_LO = 0;
  localparam int HOPS_HI = 31;
  localparam int HOPS_LO = 24;
  localparam int SDIST_HI = 15;
  localparam int SDIST_LO = 0;
  localparam int DDIST_HI = 31;
  localparam int DDIST_LO = 16;
  localparam int SSIZE_HI = 11;
  localparam int SSIZE_LO = 0;
  localparam int DSIZE_HI = 23;
  localparam int DSIZE_LO = 12;
  localparam logic [26:0] LEN_ZERO_BYTES = 27'h4000000;

  // ==========================================================================
  // Transaction and transport codes
  localparam logic [3:0] TT_NREAD = 4'h0;
  localparam logic [3:0] TT_WR_LAST_R = 4'h1;
  localparam logic [3:0] TT_WR_ALL = 4'h2;
  localparam logic [3:0] TT_WR_ALL_R = 4'h3;
  localparam logic [3:0] TT_MAINT_RD = 4'h4;
  localparam logic [3:0] TT_MAINT_WR = 4'h5;
  localparam logic [1:0] TRANSPORT_8 = 2'h0;
  localparam logic [1:0] TRANSPORT_16 = 2'h1;

  // ==========================================================================
  // Address width selection
  localparam logic [1:0] AW_34 = 2'h0;
  localparam logic [1:0] AW_50 = 2'h1;
  localparam logic [1:0] AW_66 = 2'h2;

  // ==========================================================================
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_COUNT = 4'h3;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int ST_FINISHED = 0;
  localparam int ST_BAD_KIND = 1;
  localparam int ST_BAD_CODE = 2;
  localparam logic [2:0] MASK_RESET = 3'h0;

  typedef enum logic [1:0] {
    PKT_NONE,
    PKT_WRITE,
    PKT_WRITE_R
  } ddd_pkt_t;

  // Read types decide which side each stride belongs to
  function automatic logic ddd_is_read(input logic [3:0] code);
    return (code == TT_NREAD) || (code == TT_MAINT_RD);
  endfunction

  function automatic logic ddd_is_maint(input logic [3:0] code);
    return (code == TT_MAINT_RD) || (code == TT_MAINT_WR);
  endfunction

endpackage

// *** ddd_word_store.sv ***
// Eight-word store holding the descriptor as it streams in
`timescale 1ns/1ps
module ddd_word_store
  import ddd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [31:0] wrData,
  // Read side
  input wire logic [2:0] rdIdx,
  output logic [31:0] rdData
);

  logic [31:0] mem [DWORDS];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end

endmodule

// *** ddd_irq_regs.sv ***
// Software register file with sticky status and masked interrupt
`timescale 1ns/1ps
module ddd_irq_regs
  import ddd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Block side
  input wire logic [2:0] events,
  input wire logic [31:0] doneCount,
  output logic [1:0] addrWidth,
  output logic irq
);

  logic [1:0] ctrl_reg, ctrl_next;
  logic [2:0] status_reg, status_next;
  logic [2:0] mask_reg, mask_next;
  logic [31:0] rd_reg, rd_next;
  logic irq_reg, irq_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rd_next = 32'h0;
    if (regWr && regAddr == REG_CTRL) begin
      ctrl_next = regWrData[1:0];
    end
    if (regWr && regAddr == REG_MASK) begin
      mask_next = regWrData[2:0];
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL: rd_next = {30'h0, ctrl_reg};
        REG_STATUS: begin
          rd_next = {29'h0, status_reg};
          status_next = 3'h0;
        end
        REG_MASK: rd_next = {29'h0, mask_reg};
        REG_COUNT: rd_next = doneCount;
        default: rd_next = 32'h0;
      endcase
    end
    // Set wins over the read-clear in the same cycle
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      status_reg <= 3'h0;
      mask_reg <= MASK_RESET;
      rd_reg <= 32'h0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      irq_reg <= irq_next;
    end
  end

  assign regRdData = rd_reg;
  assign addrWidth = ctrl_reg;
  assign irq = irq_reg;

endmodule

// *** ddd_decoder.sv ***
// Data transfer descriptor decoder for one block DMA channel
// ============================================================================
// What this block does
// - Descriptor kind is dword0 bits 31:29; value 1 means data transfer.
// - Transaction type dword0 22:19; 0 NREAD, 4 maintenance read, 5 maintenance write.
// - Codes 1,2,3 select write packet flavours; other codes reserved.
// - Dword0 bit 16 is critical flow, bits 15:0 target ID.
// - Interrupt-when-finished bit 27 sets finished flag and interrupt at completion.
// - Length from dword1 25:0; zero means 64 MB.
// - Transport type dword1 27:26; 0 is 8-bit IDs, 1 16-bit.
// - Fabric address from dword1 31:30, dword2 and dword3.
// - Maintenance offset dword2 23:0, hops dword2 31:24.
// - Only the 34, 50 or 66 address bits selected are used.
// - Host buffer address low from dword4, high from dword5.
// - Stride distances in dword6 are signed byte values.
// - Reads: source stride on fabric; writes: source stride on host.
// - Stride sizes from dword7 11:0 and 23:12; zero means infinite.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module ddd_decoder
  import ddd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Descriptor dword stream, dword 0 first
  input wire logic descValid,
  input wire logic [31:0] descWord,
  // Completion from the request generators
  input wire logic descDone,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic irq,
  // Decoded descriptor
  output logic outValid,
  output logic outIsData,
  output logic [3:0] transactionType,
  output logic [1:0] outPacketKind,
  output logic [1:0] outPriority,
  output logic outCritical,
  output logic [15:0] targetId,
  output logic interruptWhenFinished,
  output logic [26:0] transferLength,
  output logic [1:0] transportType,
  output logic wideIds,
  output logic isMaint,
  output logic [65:0] fabricAddress,
  output logic [23:0] maintenanceOffset,
  output logic [7:0] maintenanceHops,
  output logic [63:0] hostBufferAddress,
  output logic [15:0] fabricStrideDistance,
  output logic [15:0] hostStrideDistance,
  output logic [11:0] fabricStrideSize,
  output logic [11:0] hostStrideSize,
  output logic fabricStrideInfinite,
  output logic hostStrideInfinite
);

  // ==========================================================================
  // Collection state
  typedef enum logic [1:0] {
    S_COLLECT,
    S_DECODE,
    S_BUSY
  } ddd_state_t;

  ddd_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic [2:0] rdIdx_reg, rdIdx_next;
  logic [2:0] phase_reg, phase_next;
  logic ldValid_reg, ldValid_next;
  logic [31:0] storeRd;
  logic [1:0] addrWidth;
  logic [2:0] events;
  logic [31:0] count_reg, count_next;

  ddd_word_store u_store (
    .clk(clk),
    .wrEn(descValid && state_reg == S_COLLECT),
    .wrIdx(idx_reg),
    .wrData(descWord),
    .rdIdx(rdIdx_reg),
    .rdData(storeRd)
  );

  // ==========================================================================
  // Decoded fields
  logic [31:0] w0_reg, w0_next, w1_reg, w1_next, w2_reg, w2_next, w3_reg, w3_next;
  logic [31:0] w4_reg, w4_next, w5_reg, w5_next, w6_reg, w6_next, w7_reg, w7_next;
  logic valid_reg, valid_next;
  logic iwf_reg, iwf_next;
  logic badKind_reg, badKind_next;
  logic badCode_reg, badCode_next;

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    rdIdx_next = rdIdx_reg;
    phase_next = phase_reg;
    ldValid_next = 1'b0;
    w0_next = w0_reg;
    w1_next = w1_reg;
    w2_next = w2_reg;
    w3_next = w3_reg;
    w4_next = w4_reg;
    w5_next = w5_reg;
    w6_next = w6_reg;
    w7_next = w7_reg;
    valid_next = valid_reg;
    iwf_next = iwf_reg;
    badKind_next = 1'b0;
    badCode_next = 1'b0;
    count_next = count_reg;
    events = 3'h0;
    case (state_reg)
      S_COLLECT: begin
        if (descValid) begin
          idx_next = idx_reg + 3'h1;
          if (idx_reg == LAST_DWORD) begin
            state_next = S_DECODE;
            rdIdx_next = 3'h0;
            phase_next = 3'h0;
          end
        end
      end
      S_DECODE: begin
        // Store read data lags the index by one cycle
        rdIdx_next = rdIdx_reg + 3'h1;
        ldValid_next = 1'b1;
        if (ldValid_reg) begin
          phase_next = phase_reg + 3'h1;
          case (phase_reg)
            3'h0: w0_next = storeRd;
            3'h1: w1_next = storeRd;
            3'h2: w2_next = storeRd;
            3'h3: w3_next = storeRd;
            3'h4: w4_next = storeRd;
            3'h5: w5_next = storeRd;
            3'h6: w6_next = storeRd;
            default: w7_next = storeRd;
          endcase
          if (phase_reg == LAST_DWORD) begin
            state_next = S_BUSY;
            valid_next = 1'b1;
            ldValid_next = 1'b0;
            iwf_next = w0_reg[IWF_BIT];
            badKind_next = w0_reg[KIND_HI:KIND_LO] != KIND_DATA;
            badCode_next = w0_reg[TTYPE_HI:TTYPE_LO] > TT_MAINT_WR ||
              w1_reg[TT_HI] != 1'b0;
          end
        end
      end
      S_BUSY: begin
        if (descDone) begin
          state_next = S_COLLECT;
          valid_next = 1'b0;
          idx_next = 3'h0;
          count_next = count_reg + 32'h1;
          events[ST_FINISHED] = iwf_reg;
        end
      end
      default: state_next = S_COLLECT;
    endcase
    events[ST_BAD_KIND] = badKind_reg;
    events[ST_BAD_CODE] = badCode_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_COLLECT;
      idx_reg <= 3'h0;
      rdIdx_reg <= 3'h0;
      phase_reg <= 3'h0;
      ldValid_reg <= 1'b0;
      w0_reg <= 32'h0;
      w1_reg <= 32'h0;
      w2_reg <= 32'h0;
      w3_reg <= 32'h0;
      w4_reg <= 32'h0;
      w5_reg <= 32'h0;
      w6_reg <= 32'h0;
      w7_reg <= 32'h0;
      valid_reg <= 1'b0;
      iwf_reg <= 1'b0;
      badKind_reg <= 1'b0;
      badCode_reg <= 1'b0;
      count_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      rdIdx_reg <= rdIdx_next;
      phase_reg <= phase_next;
      ldValid_reg <= ldValid_next;
      w0_reg <= w0_next;
      w1_reg <= w1_next;
      w2_reg <= w2_next;
      w3_reg <= w3_next;
      w4_reg <= w4_next;
      w5_reg <= w5_next;
      w6_reg <= w6_next;
      w7_reg <= w7_next;
      valid_reg <= valid_next;
      iwf_reg <= iwf_next;
      badKind_reg <= badKind_next;
      badCode_reg <= badCode_next;
      count_reg <= count_next;
    end
  end

  ddd_irq_regs u_regs (
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .events(events),
    .doneCount(count_reg),
    .addrWidth(addrWidth),
    .irq(irq)
  );

  // ==========================================================================
  // Field extraction from the next word values, so the fields register in step with the words
  typedef struct packed {
    logic isData;
    logic [3:0] code;
    logic [1:0] pkt;
    logic [1:0] prio;
    logic crit;
    logic [15:0] tid;
    logic [26:0] len;
    logic [1:0] tt;
    logic wide;
    logic maint;
    logic [65:0] fabric;
    logic [23:0] ofs;
    logic [7:0] hops;
    logic [63:0] host;
    logic [15:0] fDist;
    logic [15:0] hDist;
    logic [11:0] fSize;
    logic [11:0] hSize;
    logic fInf;
    logic hInf;
  } ddd_fields_t;

  ddd_fields_t fields_reg, fields_next;
  logic [3:0] code;
  logic rdType;
  logic [65:0] addrMask;

  assign code = w0_next[TTYPE_HI:TTYPE_LO];
  assign rdType = ddd_is_read(code);

  always_comb begin
    case (addrWidth)
      AW_34: addrMask = {32'h0, {34{1'b1}}};
      AW_50: addrMask = {16'h0, {50{1'b1}}};
      default: addrMask = {66{1'b1}};
    endcase
    fields_next.isData = w0_next[KIND_HI:KIND_LO] == KIND_DATA;
    fields_next.code = code;
    case (code)
      TT_NREAD, TT_MAINT_RD: fields_next.pkt = PKT_NONE;
      TT_WR_LAST_R: fields_next.pkt = valid_next ? PKT_WRITE : PKT_NONE;
      TT_WR_ALL, TT_MAINT_WR: fields_next.pkt = PKT_WRITE;
      TT_WR_ALL_R: fields_next.pkt = PKT_WRITE_R;
      default: fields_next.pkt = PKT_NONE;
    endcase
    fields_next.prio = w0_next[PRIO_HI:PRIO_LO];
    fields_next.crit = w0_next[CRF_BIT];
    fields_next.tid = w0_next[TID_HI:TID_LO];
    // Zero length stands for the full 64 MB
    fields_next.len = (w1_next[LEN_HI:LEN_LO] == 26'h0) ? LEN_ZERO_BYTES :
      {1'b0, w1_next[LEN_HI:LEN_LO]};
    fields_next.tt = w1_next[TT_HI:TT_LO];
    fields_next.wide = w1_next[TT_HI:TT_LO] == TRANSPORT_16;
    fields_next.maint = ddd_is_maint(code);
    fields_next.fabric = fields_next.maint ? 66'h0 :
      ({w3_next, w2_next, w1_next[FA_LOW_HI:FA_LOW_LO]} & addrMask);
    fields_next.ofs = fields_next.maint ? w2_next[CFG_OFS_HI:CFG_OFS_LO] : 24'h0;
    fields_next.hops = fields_next.maint ? w2_next[HOPS_HI:HOPS_LO] : 8'h0;
    fields_next.host = {w5_next, w4_next};
    // Stride distances pass as raw two's complement; consumers sign-extend
    fields_next.fDist = rdType ? w6_next[SDIST_HI:SDIST_LO] : w6_next[DDIST_HI:DDIST_LO];
    fields_next.hDist = rdType ? w6_next[DDIST_HI:DDIST_LO] : w6_next[SDIST_HI:SDIST_LO];
    fields_next.fSize = rdType ? w7_next[SSIZE_HI:SSIZE_LO] : w7_next[DSIZE_HI:DSIZE_LO];
    fields_next.hSize = rdType ? w7_next[DSIZE_HI:DSIZE_LO] : w7_next[SSIZE_HI:SSIZE_LO];
    fields_next.fInf = fields_next.fSize == 12'h0;
    fields_next.hInf = fields_next.hSize == 12'h0;
  end

  // No reset of its own: the words are cleared by reset and settle here one cycle later
  always_ff @(posedge clk) begin
    fields_reg <= fields_next;
  end

  assign outValid = valid_reg;
  assign outIsData = fields_reg.isData;
  assign transactionType = fields_reg.code;
  assign outPacketKind = fields_reg.pkt;
  assign outPriority = fields_reg.prio;
  assign outCritical = fields_reg.crit;
  assign targetId = fields_reg.tid;
  assign interruptWhenFinished = iwf_reg;
  assign transferLength = fields_reg.len;
  assign transportType = fields_reg.tt;
  assign wideIds = fields_reg.wide;
  assign isMaint = fields_reg.maint;
  assign fabricAddress = fields_reg.fabric;
  assign maintenanceOffset = fields_reg.ofs;
  assign maintenanceHops = fields_reg.hops;
  assign hostBufferAddress = fields_reg.host;
  assign fabricStrideDistance = fields_reg.fDist;
  assign hostStrideDistance = fields_reg.hDist;
  assign fabricStrideSize = fields_reg.fSize;
  assign hostStrideSize = fields_reg.hSize;
  assign fabricStrideInfinite = fields_reg.fInf;
  assign hostStrideInfinite = fields_reg.hInf;

endmodule

// *** ddd_decoder_monitor.sv ***
// Checker that compares the decoded fields with a shadow copy of the dword stream
`timescale 1ns/1ps
module ddd_decoder_monitor
  import ddd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stream side
  input wire logic descValid,
  input wire logic [31:0] descWord,
  input wire logic descDone,
  // Decoded side
  input wire logic outValid,
  input wire logic outIsData,
  input wire logic [3:0] transactionType,
  input wire logic [1:0] outPacketKind,
  input wire logic [1:0] outPriority,
  input wire logic outCritical,
  input wire logic [15:0] targetId,
  input wire logic [26:0] transferLength,
  input wire logic [1:0] transportType,
  input wire logic wideIds,
  input wire logic isMaint,
  input wire logic [65:0] fabricAddress,
  input wire logic [23:0] maintenanceOffset,
  input wire logic [7:0] maintenanceHops,
  input wire logic [63:0] hostBufferAddress,
  input wire logic [15:0] fabricStrideDistance,
  input wire logic [15:0] hostStrideDistance
);
  // ========
  // Shadow record; only valid because the stream stays idle while a record is decoded
  logic [2:0] idxReg;
  logic [31:0] wr [8];
  logic [3:0] ty;
  logic rd;
  assign ty = wr[0][TTYPE_HI:TTYPE_LO];
  assign rd = ty == TT_NREAD || ty == TT_MAINT_RD;
  always_ff @(posedge clk) begin
    if (rst) begin
      idxReg <= 3'h0;
    end else if (descValid) begin
      wr[idxReg] <= descWord;
      idxReg <= idxReg + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ========
  // Assertions
  chk_decode_latency: assert property (descValid && idxReg == LAST_DWORD |-> ##[1:20] outValid)
    else $error("decode did not finish in time");
  chk_done_release: assert property (outValid && descDone |=> !outValid)
    else $error("result held after done");
  chk_kind_flag: assert property (outValid |-> outIsData == (wr[0][KIND_HI:KIND_LO] == KIND_DATA))
    else $error("data kind flag wrong");
  chk_type_route: assert property (outValid |-> transactionType == ty && outPriority == wr[0][18:17]
    && outCritical == wr[0][16] && targetId == wr[0][15:0]) else $error("dword0 fields wrong");
  chk_packet_kind: assert property (outValid && ty == TT_WR_ALL_R |-> outPacketKind == 2'h2)
    else $error("packet kind wrong");
  chk_length_zero: assert property (outValid && wr[1][25:0] == 26'h0 |-> transferLength == LEN_ZERO_BYTES)
    else $error("zero length not widened");
  chk_transport_ids: assert property (outValid |-> transportType == wr[1][27:26]
    && wideIds == (wr[1][27:26] == TRANSPORT_16)) else $error("transport wrong");
  chk_fabric_low: assert property (outValid && !isMaint |-> fabricAddress[33:0] == {wr[2], wr[1][31:30]})
    else $error("fabric address wrong");
  chk_maint_fields: assert property (outValid && isMaint |-> maintenanceOffset == wr[2][23:0]
    && maintenanceHops == wr[2][31:24]) else $error("maintenance fields wrong");
  chk_host_addr: assert property (outValid |-> hostBufferAddress == {wr[5], wr[4]})
    else $error("host address wrong");
  chk_stride_side: assert property (outValid |->
    fabricStrideDistance == (rd ? wr[6][15:0] : wr[6][31:16]) && hostStrideDistance == (rd ? wr[6][31:16] : wr[6][15:0]))
    else $error("stride side wrong");
endmodule

bind ddd_decoder ddd_decoder_monitor mon (.clk, .rst, .descValid, .descWord, .descDone, .outValid, .outIsData,
  .transactionType, .outPacketKind, .outPriority, .outCritical, .targetId, .transferLength, .transportType, .wideIds,
  .isMaint, .fabricAddress, .maintenanceOffset, .maintenanceHops, .hostBufferAddress, .fabricStrideDistance,
  .hostStrideDistance);

// *** ddd_host_model.sv ***
// Host memory model that streams one descriptor record as eight dwords
`timescale 1ns/1ps
module ddd_host_model (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] gap,
  input wire logic [31:0] desc [8],
  // Dword stream
  output logic descValid,
  output logic [31:0] descWord
);
  logic busy;
  logic [2:0] idx;
  logic [3:0] cnt;
  logic [31:0] lastWord;
  // Released data shows the inverse so a late sample cannot match by luck
  assign descWord = descValid ? lastWord : ~lastWord;
  always @(posedge clk) begin
    descValid <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      lastWord <= 32'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      idx <= 3'h0;
      cnt <= 4'h0;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      descValid <= 1'b1;
      lastWord <= desc[idx];
      idx <= idx + 3'h1;
      cnt <= gap;
      busy <= idx != 3'h7;
    end
  end
endmodule

// *** tb_dma_data_descriptor_decoder.sv ***
// Self-checking testbench for the data transfer descriptor decoder
`timescale 1ns/1ps
module tb_dma_data_descriptor_decoder
  import ddd_pkg::*;
;
  // ========
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [31:0] desc [8];
  logic descValid, outValid, outIsData, outCritical, interruptWhenFinished, wideIds, isMaint, irq;
  logic fabricStrideInfinite, hostStrideInfinite;
  logic [31:0] descWord, regRdData;
  logic descDone = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] transactionType;
  logic [1:0] outPacketKind, outPriority, transportType;
  logic [15:0] targetId, fabricStrideDistance, hostStrideDistance;
  logic [26:0] transferLength;
  logic [65:0] fabricAddress;
  logic [23:0] maintenanceOffset;
  logic [7:0] maintenanceHops;
  logic [63:0] hostBufferAddress;
  logic [11:0] fabricStrideSize, hostStrideSize;
  logic [2:0] st;
  int failures = 0;
  int checked = 0;
  ddd_host_model host (.clk, .rst, .start, .gap, .desc, .descValid, .descWord);
  ddd_decoder dut (.clk, .rst, .descValid, .descWord, .descDone, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .irq, .outValid, .outIsData, .transactionType, .outPacketKind, .outPriority, .outCritical, .targetId,
    .interruptWhenFinished, .transferLength, .transportType, .wideIds, .isMaint, .fabricAddress, .maintenanceOffset,
    .maintenanceHops, .hostBufferAddress, .fabricStrideDistance, .hostStrideDistance, .fabricStrideSize,
    .hostStrideSize, .fabricStrideInfinite, .hostStrideInfinite);
  always #4 clk = ~clk;
  // ========
  // Tasks
  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [65:0] e, input logic [65:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    cmp("regRdData", e, regRdData);
  endtask
  // Record i: codes 0..5 in turn, 6 is a foreign kind, 7 a reserved code; 2 has reserved bits set
  task automatic setDesc(input int i);
    logic mt;
    mt = i == 4 || i == 5;
    desc[0] = {i == 6 ? 3'h2 : 3'h1, 1'(i == 2), 1'(i % 2 == 1 && i < 6), {4{i == 2}},
      i == 7 ? 4'h7 : (i == 6 ? 4'h0 : 4'(i)), 2'(i % 3), 1'(i % 2), 16'hA5C0 + 16'(i)};
    desc[1] = {2'(i + 1), {2{i == 2}}, 2'(i % 2), mt ? 26'h4 : (i == 2 ? 26'h0 : 26'h3FFFFFF - 26'(i))};
    desc[2] = mt ? {8'(3 + i), 22'h1A2B3C, 2'h0} : 32'h89ABCDEF ^ 32'(i);
    desc[3] = 32'hF00D0000 | 32'(i);
    desc[4] = 32'h10000040 + 32'(i);
    desc[5] = 32'hFEED0000 + 32'(i);
    desc[6] = {16'hFFF0 - 16'(i), 16'h0020 + 16'(i)};
    desc[7] = {{8{i == 2}}, i == 0 ? 12'h0 : 12'(i * 8), i == 3 ? 12'h0 : 12'h100 + 12'(i)};
  endtask
  task automatic checkFields(input logic [1:0] aw);
    logic [3:0] c;
    logic rd;
    logic mt;
    logic [65:0] fa;
    logic [1:0] pk;
    logic [23:0] sz;
    c = desc[0][22:19];
    rd = c == TT_NREAD || c == TT_MAINT_RD;
    mt = c == TT_MAINT_RD || c == TT_MAINT_WR;
    fa = mt ? 66'h0 : {desc[3], desc[2], desc[1][31:30]};
    if (aw == AW_34) fa[65:34] = 32'h0;
    if (aw == AW_50) fa[65:50] = 16'h0;
    cmp("isData", desc[0][31:29] == KIND_DATA, outIsData);
    cmp("type", c, transactionType);
    pk = c == TT_WR_ALL_R ? 2'h2 : {1'b0, c == TT_WR_LAST_R || c == TT_WR_ALL || c == TT_MAINT_WR};
    if (c <= 4'h5) cmp("pkt", pk, outPacketKind);
    cmp("dw0", {desc[0][18:16], desc[0][15:0]}, {outPriority, outCritical, targetId});
    cmp("iwf", desc[0][27], interruptWhenFinished);
    cmp("len", desc[1][25:0] == 26'h0 ? LEN_ZERO_BYTES : {1'b0, desc[1][25:0]}, transferLength);
    cmp("tt", {desc[1][27:26], desc[1][27:26] == TRANSPORT_16}, {transportType, wideIds});
    cmp("fabric", fa, fabricAddress);
    cmp("maint", {mt, mt ? desc[2][31:24] : 8'h0}, {isMaint, maintenanceHops});
    cmp("ofs", mt ? desc[2][23:0] : 24'h0, maintenanceOffset);
    cmp("host", {desc[5], desc[4]}, hostBufferAddress);
    cmp("dist", rd ? desc[6] : {desc[6][15:0], desc[6][31:16]},
      {hostStrideDistance, fabricStrideDistance});
    sz = rd ? desc[7][23:0] : {desc[7][11:0], desc[7][23:12]};
    cmp("size", sz, {hostStrideSize, fabricStrideSize});
    cmp("inf", {sz[23:12] == 12'h0, sz[11:0] == 12'h0}, {hostStrideInfinite, fabricStrideInfinite});
  endtask
  task automatic runDesc(input logic [3:0] g, input logic [1:0] aw);
    int n;
    @(posedge clk);
    gap <= g;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (outValid !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) begin
      failures++;
      conclude();
    end
    checkFields(aw);
    @(posedge clk);
    descDone <= 1'b1;
    @(posedge clk);
    descDone <= 1'b0;
  endtask
  // ========
  // Sequence
  initial begin
    for (int k = 0; k < 8; k++) desc[k] = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp("irq", 1'b0, irq);
    cmp("len", LEN_ZERO_BYTES, transferLength);
    regRead(REG_CTRL, 32'h2);
    regRead(REG_MASK, 32'h0);
    regRead(4'hF, 32'h0);
    regWrite(REG_MASK, 32'h5);
    for (int i = 0; i < 8; i++) begin
      setDesc(i);
      runDesc(4'(i), AW_66);
      st = i == 6 ? 3'h2 : (i == 7 ? 3'h4 : {2'h0, desc[0][27]});
      repeat (2) @(posedge clk);
      #1;
      cmp("irq", |(st & 3'h5), irq);
      regRead(REG_STATUS, 32'(st));
      regRead(REG_STATUS, 32'h0);
      cmp("irq", 1'b0, irq);
    end
    regRead(REG_COUNT, 32'h8);
    for (int a = 0; a < 3; a++) begin
      regWrite(REG_CTRL, 32'(a));
      setDesc(1);
      runDesc(4'h0, 2'(a));
    end
    conclude();
  end
endmodule
